// File: design/kbpt_pkg.sv
// Constants shared by the keyboard pass-through port.
// Assumes a 25 MHz system clock and byte-wide processor data.
package kbpt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] KBPT_DATA_ADDR = 32'h1000_0700;
  localparam logic [31:0] KBPT_STAT_ADDR = 32'h1000_0704;
  localparam logic [7:0] KBPT_RXBUF_RESET = 8'h00;
  localparam logic [7:0] KBPT_UNMAPPED_DATA = 8'h00;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int KBPT_ST_RX_FULL = 0;
  localparam int KBPT_ST_TX_FULL = 1;
  localparam int KBPT_ST_PAR_ERR = 2;
  localparam int KBPT_ST_ACK_ERR = 3;
  localparam int KBPT_ST_BUSY = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int KBPT_CLK_PERIOD_NS = 40;
  localparam int KBPT_INHIBIT_NS = 100000;
  localparam int KBPT_INHIBIT_CYC =
    (KBPT_INHIBIT_NS + KBPT_CLK_PERIOD_NS - 1) / KBPT_CLK_PERIOD_NS;
  localparam int KBPT_TIMEOUT_NS = 2000000;
  localparam int KBPT_TIMEOUT_CYC = KBPT_TIMEOUT_NS / KBPT_CLK_PERIOD_NS;
  localparam int KBPT_TIMER_W = 16;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [3:0] KBPT_BIT_PARITY = 4'h9;
  localparam logic [3:0] KBPT_BIT_STOP = 4'ha;
  localparam logic [3:0] KBPT_TX_LAST_DATA = 4'h8;

  typedef enum logic [3:0] {
    KBPT_IDLE = 4'b0001,
    KBPT_RX = 4'b0010,
    KBPT_INHIBIT = 4'b0100,
    KBPT_TX = 4'b1000
  } kbpt_state_e;

endpackage

// File: design/kbpt_sync2.sv
// Two-stage synchroniser for a level arriving from another domain.
// Assumes an asynchronous active-low reset and a clock enable.
`timescale 1ns/1ps
module kbpt_sync2 #(
  parameter logic RESET_VAL = 1'b1
)
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Level
  input wire logic d,
  output logic q
);

  logic meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// File: design/kbpt_odd_parity.sv
// Odd parity bit over a data word.
// Purely combinational.
`timescale 1ns/1ps
module kbpt_odd_parity #(
  parameter int W = 8
)
(
  // Data in
  input wire logic [W-1:0] data,
  // Parity out: makes the count of ones odd
  output logic par
);

  initial
  begin
    if (W < 1)
      $error("kbpt_odd_parity: W must be at least 1");
  end

  assign par = ~(^data);

endmodule

// File: design/kbpt_port.sv
// Keyboard pass-through port: byte register port to a two-wire link.
// Assumes link clock and data arrive from another domain and that the
// pad logic resolves each open-drain line from its enable.
`timescale 1ns/1ps
module kbpt_port
  import kbpt_pkg::*;
#(
  parameter int INHIBIT_CYCLES = kbpt_pkg::KBPT_INHIBIT_CYC,
  parameter int TIMEOUT_CYCLES = kbpt_pkg::KBPT_TIMEOUT_CYC
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Processor register port
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Ready lines to the processor
  output logic transmit_slot_free_irq,
  output logic receive_byte_waiting_irq,
  // Keyboard link, open-drain
  input wire logic kb_clk_i,
  output logic kb_clk_o,
  output logic kb_clk_oe,
  input wire logic kb_dat_i,
  output logic kb_dat_o,
  output logic kb_dat_oe
);

  initial
  begin
    if (INHIBIT_CYCLES < 1 || INHIBIT_CYCLES >= (1 << KBPT_TIMER_W))
      $error("kbpt_port: INHIBIT_CYCLES out of range");
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << KBPT_TIMER_W))
      $error("kbpt_port: TIMEOUT_CYCLES out of range");
  end

  localparam logic [KBPT_TIMER_W-1:0] INHIBIT_LAST =
    KBPT_TIMER_W'(INHIBIT_CYCLES - 1);
  localparam logic [KBPT_TIMER_W-1:0] TIMEOUT_LAST =
    KBPT_TIMER_W'(TIMEOUT_CYCLES - 1);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ****************************************
  // Link inputs and edge detection
  // ****************************************
  logic kb_clk_s;
  logic kb_dat_s;
  logic kb_clk_prev_r;
  logic clk_fall;

  kbpt_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_clk (
    .clk(clk),
    .rst_n(rst_n_r),
    .ce(ce),
    .d(kb_clk_i),
    .q(kb_clk_s)
  );

  kbpt_sync2 #(
    .RESET_VAL(1'b1)
  ) u_sync_dat (
    .clk(clk),
    .rst_n(rst_n_r),
    .ce(ce),
    .d(kb_dat_i),
    .q(kb_dat_s)
  );

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      kb_clk_prev_r <= 1'b1;
    else if (ce)
      kb_clk_prev_r <= kb_clk_s;
  end

  assign clk_fall = kb_clk_prev_r & ~kb_clk_s;

  // ****************************************
  // Register access decode
  // ****************************************
  logic data_sel;
  logic stat_sel;
  logic data_rd;
  logic data_wr;
  logic tx_full_r;
  logic rx_full_r;
  logic [7:0] rx_buf_r;
  logic [7:0] tx_buf_r;
  logic par_err_r;
  logic ack_err_r;
  logic rx_done_r;
  logic tx_done_r;
  logic [7:0] rx_byte_r;
  logic rx_bad_r;
  logic ack_bad_r;
  kbpt_state_e state_r;
  logic [7:0] status;

  assign data_sel = cs && (addr == KBPT_DATA_ADDR);
  assign stat_sel = cs && (addr == KBPT_STAT_ADDR);
  assign data_rd = data_sel && rd;
  assign data_wr = data_sel && wr;

  always_comb
  begin
    status = 8'h00;
    status[KBPT_ST_RX_FULL] = rx_full_r;
    status[KBPT_ST_TX_FULL] = tx_full_r;
    status[KBPT_ST_PAR_ERR] = par_err_r;
    status[KBPT_ST_ACK_ERR] = ack_err_r;
    status[KBPT_ST_BUSY] = (state_r != KBPT_IDLE);
  end

  // ****************************************
  // Buffers and flags
  // ****************************************
  // write while not full loads buffer and sets full
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_full_r <= 1'b0;
      tx_buf_r <= 8'h00;
    end
    else if (ce)
    begin
      if (data_wr && !tx_full_r)
      begin
        tx_full_r <= 1'b1;
        tx_buf_r <= wdata;
      end
      else if (tx_done_r)
        tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rx_full_r <= 1'b0;
      rx_buf_r <= KBPT_RXBUF_RESET;
      par_err_r <= 1'b0;
      ack_err_r <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_done_r)
      begin
        rx_full_r <= 1'b1;
        rx_buf_r <= rx_byte_r;
      end
      else if (data_rd)
        rx_full_r <= 1'b0;
      if (rx_bad_r)
        par_err_r <= 1'b1;
      else if (rx_done_r)
        par_err_r <= 1'b0;
      if (ack_bad_r)
        ack_err_r <= 1'b1;
      else if (data_wr && !tx_full_r)
        ack_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rdata <= 8'h00;
    else if (ce && cs && rd)
    begin
      if (data_sel)
        rdata <= rx_buf_r;
      else if (stat_sel)
        rdata <= status;
      else
        rdata <= KBPT_UNMAPPED_DATA;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      transmit_slot_free_irq <= 1'b1;
      receive_byte_waiting_irq <= 1'b0;
    end
    else if (ce)
    begin
      transmit_slot_free_irq <= ~tx_full_r;
      receive_byte_waiting_irq <= rx_full_r;
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [8:0] tx_shift_r;
  logic [KBPT_TIMER_W-1:0] timer_r;
  logic rx_par_r;
  logic tx_par;

  kbpt_odd_parity #(
    .W(8)
  ) u_tx_par (
    .data(tx_buf_r),
    .par(tx_par)
  );

  // Lines are never driven high
  assign kb_clk_o = 1'b0;
  assign kb_dat_o = 1'b0;

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= KBPT_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_shift_r <= 9'h000;
      timer_r <= '0;
      rx_par_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_done_r <= 1'b0;
      rx_bad_r <= 1'b0;
      tx_done_r <= 1'b0;
      ack_bad_r <= 1'b0;
      kb_clk_oe <= 1'b0;
      kb_dat_oe <= 1'b0;
    end
    else if (ce)
    begin
      rx_done_r <= 1'b0;
      rx_bad_r <= 1'b0;
      tx_done_r <= 1'b0;
      ack_bad_r <= 1'b0;
      if (state_r == KBPT_IDLE || (clk_fall && state_r != KBPT_INHIBIT))
        timer_r <= '0;
      else if (timer_r != TIMEOUT_LAST)
        timer_r <= timer_r + 1'b1;
      case (state_r)
        KBPT_IDLE:
        begin
          // start bit low opens a frame
          if (clk_fall && !kb_dat_s)
          begin
            state_r <= KBPT_RX;
            bit_cnt_r <= 4'h1;
          end
          else if (tx_full_r && !tx_done_r)
          begin
            // hold clock low to claim link
            state_r <= KBPT_INHIBIT;
            kb_clk_oe <= 1'b1;
            tx_shift_r <= {tx_par, tx_buf_r};
          end
        end
        KBPT_RX:
        begin
          if (timer_r == TIMEOUT_LAST)
            state_r <= KBPT_IDLE;
          else if (clk_fall)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r < KBPT_BIT_PARITY)
              shift_r <= {kb_dat_s, shift_r[7:1]};
            else if (bit_cnt_r == KBPT_BIT_PARITY)
              rx_par_r <= kb_dat_s;
            else
            begin
              state_r <= KBPT_IDLE;
              if (kb_dat_s && (^{shift_r, rx_par_r}))
              begin
                rx_done_r <= 1'b1;
                rx_byte_r <= shift_r;
              end
              else
                rx_bad_r <= 1'b1;
            end
          end
        end
        KBPT_INHIBIT:
        begin
          if (timer_r == INHIBIT_LAST)
          begin
            // start bit by pulling data low
            state_r <= KBPT_TX;
            kb_dat_oe <= 1'b1;
            kb_clk_oe <= 1'b0;
            bit_cnt_r <= 4'h0;
          end
        end
        KBPT_TX:
        begin
          if (timer_r == TIMEOUT_LAST)
          begin
            state_r <= KBPT_IDLE;
            kb_dat_oe <= 1'b0;
            tx_done_r <= 1'b1;
            ack_bad_r <= 1'b1;
          end
          else if (clk_fall)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r <= KBPT_TX_LAST_DATA)
            begin
              kb_dat_oe <= ~tx_shift_r[0];
              tx_shift_r <= {1'b0, tx_shift_r[8:1]};
            end
            else if (bit_cnt_r == KBPT_BIT_PARITY)
              kb_dat_oe <= 1'b0;
            else
            begin
              state_r <= KBPT_IDLE;
              tx_done_r <= 1'b1;
              ack_bad_r <= kb_dat_s;
            end
          end
        end
        default:
        begin
          state_r <= KBPT_IDLE;
          kb_clk_oe <= 1'b0;
          kb_dat_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: testbench/kbpt_port_monitor.sv
// Checker for the keyboard port register side and link pins.
// Bound to kbpt_port; sees only its ports.
`timescale 1ns/1ps
module kbpt_port_monitor
  import kbpt_pkg::*;
#(
  parameter int INHIBIT_CYCLES = 2500,
  parameter int TIMEOUT_CYCLES = 50000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic cs,
  input wire logic rd,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [7:0] rdata,
  // Ready lines and link
  input wire logic transmit_slot_free_irq,
  input wire logic receive_byte_waiting_irq,
  input wire logic kb_clk_o,
  input wire logic kb_clk_oe,
  input wire logic kb_dat_o,
  input wire logic kb_dat_oe
);
  logic txr, rxr, rd_dat, rd_st;
  int inh_cnt_r;
  assign txr = transmit_slot_free_irq;
  assign rxr = receive_byte_waiting_irq;
  assign rd_dat = ce && cs && rd && addr == KBPT_DATA_ADDR;
  assign rd_st = ce && cs && rd && addr == KBPT_STAT_ADDR;
  // Length of the clock inhibit
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      inh_cnt_r <= 0;
    else
      inh_cnt_r <= kb_clk_oe ? inh_cnt_r + 1 : 0;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_pull_only: assert property (
    kb_clk_o == 1'b0 && kb_dat_o == 1'b0)
    else $error("link pull value not low");
  a_reset_ready: assert property (
    $rose(rstn) |-> txr && !rxr)
    else $error("ready lines wrong after reset");
  a_write_full: assert property (
    ce && cs && wr && addr == KBPT_DATA_ADDR && txr |-> ##2 !txr)
    else $error("write did not fill transmit buffer");
  a_read_clears: assert property (
    rd_dat |-> ##2 !rxr)
    else $error("read did not clear receive ready");
  a_status_flags: assert property (
    rd_st |=> rdata[1:0] == {!txr, rxr})
    else $error("status flags disagree with ready lines");
  a_rdata_holds: assert property (
    !(ce && cs && rd) |=> $stable(rdata))
    else $error("read data changed without read");
  a_idle_released: assert property (
    txr |-> !kb_clk_oe && !kb_dat_oe)
    else $error("link pulled while transmit empty");
  a_busy_full: assert property (
    kb_clk_oe |-> !txr)
    else $error("transmit ready during inhibit");
  a_start_bit: assert property (
    $fell(kb_clk_oe) |-> kb_dat_oe)
    else $error("no start bit after inhibit");
  a_inhibit_len: assert property (
    $fell(kb_clk_oe) |-> inh_cnt_r == INHIBIT_CYCLES)
    else $error("inhibit length wrong");
endmodule

// File: testbench/kbpt_kbd_model.sv
// Keyboard at the far end of the two-wire link.
// Lines are resolved in the bench; a pull output high pulls low.
`timescale 1ns/1ps
module kbpt_kbd_model
(
  // Resolved lines
  input wire logic clk_line,
  input wire logic dat_line,
  // Pulls
  output logic clk_pull,
  output logic dat_pull
);
  localparam int HALF = 160;
  initial
  begin
    clk_pull = 1'b0;
    dat_pull = 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      dat_pull = !f[i];
      #(HALF / 2);
      clk_pull = 1'b1;
      #HALF;
      clk_pull = 1'b0;
      #(HALF / 2);
    end
    dat_pull = 1'b0;
  endtask
  // frame from the port, then acknowledge
  task automatic get(output logic [9:0] v);
    wait (!clk_line);
    wait (clk_line);
    #(3 * HALF);
    for (int i = 0; i < 11; i++)
    begin
      clk_pull = 1'b1;
      #HALF;
      clk_pull = 1'b0;
      if (i < 10)
        v[i] = dat_line;
      if (i == 9)
        dat_pull = 1'b1;
      #HALF;
    end
    dat_pull = 1'b0;
  endtask
endmodule

// File: testbench/kbpt_port_bench.sv
// Bench for the keyboard pass-through port.
// Drives the register port; a keyboard model works the link.
`timescale 1ns/1ps
module kbpt_port_bench;
  import kbpt_pkg::*;
  logic clk, rstn, cs, rd, wr;
  logic [31:0] addr;
  logic [7:0] wdata, rdata;
  logic txr, rxr, kco, kcoe, kdo, kdoe, kcp, kdp;
  logic [9:0] fr;
  int n_fail = 0;
  int checked = 0;
  wire kb_clk = (kcoe ? kco : 1'b1) & !kcp;
  wire kb_dat = (kdoe ? kdo : 1'b1) & !kdp;

  kbpt_port #(.INHIBIT_CYCLES(10), .TIMEOUT_CYCLES(200)) i_kbpt_port (
    .clk, .rstn, .ce(1'b1), .cs, .rd, .wr, .addr, .wdata, .rdata,
    .transmit_slot_free_irq(txr), .receive_byte_waiting_irq(rxr),
    .kb_clk_i(kb_clk), .kb_clk_o(kco), .kb_clk_oe(kcoe),
    .kb_dat_i(kb_dat), .kb_dat_o(kdo), .kb_dat_oe(kdoe));
  kbpt_kbd_model i_kbpt_kbd_model (.clk_line(kb_clk), .dat_line(kb_dat),
    .clk_pull(kcp), .dat_pull(kdp));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string s, input logic [9:0] e,
    input logic [9:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a,
    input logic [7:0] d);
    @(posedge clk);
    #2;
    cs = 1'b1;
    rd = !w;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #2;
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
  endtask
  task automatic wait_lvl(input logic r, input logic val);
    int n;
    n = 0;
    while ((r ? rxr : txr) !== val && n < 3000)
    begin
      @(posedge clk);
      #2;
      n++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("ready lines", 10'h1, {8'h0, rxr, txr});
    acc(1'b0, KBPT_STAT_ADDR, 8'h00);
    chk("status", 10'h0, {2'h0, rdata});
    acc(1'b1, KBPT_STAT_ADDR, 8'hff);
    acc(1'b0, KBPT_STAT_ADDR, 8'h00);
    chk("status after write", 10'h0, {2'h0, rdata});
    acc(1'b0, KBPT_DATA_ADDR + 32'h8, 8'h00);
    chk("unmapped", 10'h0, {2'h0, rdata});
  endtask
  task automatic t_rx();
    logic [7:0] b [3] = '{8'ha5, 8'h00, 8'hf0};
    foreach (b[i])
    begin
      i_kbpt_kbd_model.send(b[i], 1'b0);
      wait_lvl(1'b1, 1'b1);
      chk("rx ready", 10'h1, {9'h0, rxr});
      acc(1'b0, KBPT_STAT_ADDR, 8'h00);
      chk("status rx", 10'h1, {8'h0, rdata[1:0]});
      acc(1'b0, KBPT_DATA_ADDR, 8'h00);
      chk("rx byte", {2'h0, b[i]}, {2'h0, rdata});
      #80;
      chk("rx ready clear", 10'h0, {9'h0, rxr});
    end
    i_kbpt_kbd_model.send(8'h12, 1'b0);
    i_kbpt_kbd_model.send(8'h34, 1'b0);
    #400;
    acc(1'b0, KBPT_DATA_ADDR, 8'h00);
    chk("latest byte", 10'h34, {2'h0, rdata});
  endtask
  task automatic t_par();
    #200;
    i_kbpt_kbd_model.send(8'h5a, 1'b1);
    #400;
    chk("rx ready bad", 10'h0, {9'h0, rxr});
    acc(1'b0, KBPT_STAT_ADDR, 8'h00);
    chk("parity flag", 10'h1, {9'h0, rdata[2]});
  endtask
  task automatic t_tx();
    logic [7:0] c [2] = '{8'hed, 8'hf4};
    foreach (c[i])
    begin
      acc(1'b1, KBPT_DATA_ADDR, c[i]);
      acc(1'b0, KBPT_STAT_ADDR, 8'h00);
      chk("tx full", 10'h12, {2'h0, rdata});
      chk("tx ready", 10'h0, {9'h0, txr});
      fork
        i_kbpt_kbd_model.get(fr);
        acc(1'b1, KBPT_DATA_ADDR, 8'h11);
      join
      chk("tx frame", {1'b1, ~^c[i], c[i]}, fr);
      wait_lvl(1'b0, 1'b1);
      chk("tx ready again", 10'h1, {9'h0, txr});
    end
    acc(1'b0, KBPT_STAT_ADDR, 8'h00);
    chk("status after send", 10'h0, {2'h0, rdata});
  endtask
  task automatic t_noack();
    acc(1'b1, KBPT_DATA_ADDR, 8'h55);
    #80;
    chk("noack busy", 10'h0, {9'h0, txr});
    wait_lvl(1'b0, 1'b1);
    chk("noack ready", 10'h1, {9'h0, txr});
    acc(1'b0, KBPT_STAT_ADDR, 8'h00);
    chk("ack missing", 10'h8, {2'h0, rdata});
  endtask

  initial
  begin
    rstn = 1'b0;
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 32'h0;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    #2;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    t_reset();
    t_rx();
    t_tx();
    t_noack();
    t_par();
    complete_run();
  end
  initial
  begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule

bind kbpt_port kbpt_port_monitor #(
  .INHIBIT_CYCLES(INHIBIT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_kbpt_port_monitor (.clk, .rstn, .ce, .cs, .rd, .wr, .addr, .rdata,
  .transmit_slot_free_irq, .receive_byte_waiting_irq, .kb_clk_o,
  .kb_clk_oe, .kb_dat_o, .kb_dat_oe);
